/* File: inc/cmp_ctrl_pkg.sv */
package cmp_ctrl_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CMP0_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMP1_CTRL = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_POWER_MODE = 8'h14;
	localparam logic [7:0] ADDR_PORT_DIR = 8'h18;
	localparam logic [7:0] ADDR_PORT_DATA = 8'h1c;
	localparam logic [7:0] ADDR_PORT_READ = 8'h20;
	localparam logic [7:0] ADDR_IRQ_SET = 8'h24;
	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int BIT_PIN_SELECT = 7;
	localparam int BIT_ON = 6;
	localparam int BIT_INVERT = 5;
	localparam int BIT_RESULT = 4;
	localparam int BIT_PATH_INTERNAL = 3;
	localparam int BIT_HYSTERESIS = 0;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'he9;
	localparam logic [7:0] CTRL_RESET = 8'h81;
	// ------------------------------------------------------------
	// Misc
	// ------------------------------------------------------------
	localparam int NUM_CMP = 2;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/cmp_channel.sv */
`timescale 1ns/100ps
// One comparator channel: sync, polarity, change detect
module cmp_channel
	import cmp_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Control
	input wire logic on_in,
	input wire logic invert_in,
	// Analog comparator raw result
	input wire logic raw_in,
	// Status
	output logic result_out,
	output logic change_out
);
	logic [SYNC_STAGES-1:0] sync;
	logic [SYNC_STAGES-1:0] next_sync;
	logic result;
	logic next_result;
	logic change;
	logic next_change;

	assign result_out = result;
	assign change_out = change;

	// Sync raw result, then apply polarity; only last stage is used
	always_comb begin
		next_sync = {sync[SYNC_STAGES-2:0], raw_in};
		next_result = result;
		if (on_in) begin
			next_result = sync[SYNC_STAGES-1] ^ invert_in;
		end
		next_change = next_result != result;
	end

	// Keeps running regardless of any low-power mode
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync <= '0;
			result <= 1'b0;
			change <= 1'b0;
		end else begin
			sync <= next_sync;
			result <= next_result;
			change <= next_change;
		end
	end

	AST_CHANGE_TRACKS_RESULT: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		change |-> result != $past(result))
		else $error("change pulse without result change");
	AST_POLARITY: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		on_in |=> result == ($past(sync[SYNC_STAGES-1]) ^ $past(invert_in)))
		else $error("result does not follow polarity");
endmodule

/* File: rtl/dual_comparator_control.sv */
`timescale 1ns/100ps
// Contract
// - Two channels, each with its own 8-bit control register, same layout.
// - A change of a result bit sets its flag and, if enabled, its interrupt.
// - Interrupts come from a change of the stored result bit, not the pin.
// - In sleep or idle with the comparator on, a flag-setting change wakes.
// - An enabled comparator keeps running and updating in sleep or idle.
// - While on, shared port reads give 0 where direction is 1, else data.
// - Bit 7 (reset 1) hands the input pins over and drops their pull-highs.
// - Bit 6 (reset 0) switches the comparator off when 0 and on when 1.
// - Bit 5 (reset 0) passes the result when 0 and inverts it when 1.
// - Bit 4 reads 1 when plus exceeds minus, the other way round if inverted.
// - Bit 3 routes the result to the output pin only when 0 and bit 7 is 1.
// - Bits 2 and 1 are unimplemented and read as zero.
// - Bit 0 (reset 1) turns on limited hysteresis when 1.
module dual_comparator_control
	import cmp_ctrl_pkg::*;
#(
	parameter int PORT_W = 2
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog side
	input wire logic [NUM_CMP-1:0] cmp_raw_in,
	output logic [NUM_CMP-1:0] cmp_power_on_out,
	output logic [NUM_CMP-1:0] cmp_hysteresis_on_out,
	output logic [NUM_CMP-1:0] cmp_pin_select_out,
	output logic [NUM_CMP-1:0] cmp_pullup_off_out,
	// External output pins
	output logic [NUM_CMP-1:0] cmp_output_pin_out,
	output logic [NUM_CMP-1:0] cmp_output_pin_oe_out,
	// Interrupt and wake
	output logic irq_out,
	output logic wake_out
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] ctrl [NUM_CMP];
	logic [7:0] next_ctrl [NUM_CMP];
	logic [NUM_CMP-1:0] status, next_status;
	logic [NUM_CMP-1:0] irq_en, next_irq_en;
	logic [1:0] power_mode, next_power_mode;
	logic [PORT_W-1:0] port_dir, next_port_dir;
	logic [PORT_W-1:0] port_data, next_port_data;
	logic [NUM_CMP-1:0] result;
	logic [NUM_CMP-1:0] change;
	logic [NUM_CMP-1:0] event_set;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic irq, next_irq;
	logic wake, next_wake;
	logic [NUM_CMP-1:0] pin_val, next_pin_val;
	logic [NUM_CMP-1:0] pin_oe, next_pin_oe;
	logic do_write;
	logic awready, wready, arready, next_awready, next_wready, next_arready;

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	// One instance per channel, identical layout
	for (genvar i = 0; i < NUM_CMP; i++) begin : g_ch
		cmp_channel u_ch (
			.clk_sys_in(clk_sys_in),
			.reset_n_in(reset_n_in),
			.on_in(ctrl[i][BIT_ON]),
			.invert_in(ctrl[i][BIT_INVERT]),
			.raw_in(cmp_raw_in[i]),
			.result_out(result[i]),
			.change_out(change[i])
		);
		assign event_set[i] = change[i] && ctrl[i][BIT_ON];
	end

	// ------------------------------------------------------------
	// Bus handshake outputs
	// ------------------------------------------------------------
	assign s_axi_awready = awready;
	assign s_axi_wready = wready;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = arready;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign irq_out = irq;
	assign wake_out = wake;
	assign cmp_output_pin_out = pin_val;
	assign cmp_output_pin_oe_out = pin_oe;
	assign do_write = aw_held && w_held && !bvalid;

	// Analog controls straight from register bits
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			cmp_power_on_out[i] = ctrl[i][BIT_ON];
			cmp_hysteresis_on_out[i] = ctrl[i][BIT_HYSTERESIS];
			cmp_pin_select_out[i] = ctrl[i][BIT_PIN_SELECT];
			cmp_pullup_off_out[i] = ctrl[i][BIT_PIN_SELECT];
		end
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Address and data may arrive in either order; held until both
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_status = status;
		next_irq_en = irq_en;
		next_power_mode = power_mode;
		next_port_dir = port_dir;
		next_port_data = port_data;
		for (int i = 0; i < NUM_CMP; i++) begin
			next_ctrl[i] = ctrl[i];
			// Result bit is read-only, refreshed from the channel
			next_ctrl[i][BIT_RESULT] = result[i];
		end
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (w_strb[0]) begin
				case (aw_addr)
					ADDR_CMP0_CTRL, ADDR_CMP1_CTRL: begin
						next_ctrl[aw_addr[2]] = (w_data[7:0] & CTRL_WRITE_MASK)
							| {3'h0, result[aw_addr[2]], 4'h0};
					end
					ADDR_IRQ_CLEAR: next_status = status & ~w_data[NUM_CMP-1:0];
					ADDR_IRQ_SET: next_status = status | w_data[NUM_CMP-1:0];
					ADDR_IRQ_ENABLE: next_irq_en = w_data[NUM_CMP-1:0];
					ADDR_POWER_MODE: next_power_mode = w_data[1:0];
					ADDR_PORT_DIR: next_port_dir = w_data[PORT_W-1:0];
					ADDR_PORT_DATA: next_port_data = w_data[PORT_W-1:0];
					ADDR_IRQ_STATUS, ADDR_PORT_READ: next_bresp = RESP_OKAY;
					default: next_bresp = RESP_SLVERR;
				endcase
			end
		end
		// Hardware set wins over a same-cycle clear
		next_status = next_status | event_set;
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			case (s_axi_araddr)
				ADDR_CMP0_CTRL: next_rdata[7:0] = ctrl[0];
				ADDR_CMP1_CTRL: next_rdata[7:0] = ctrl[1];
				ADDR_IRQ_STATUS: next_rdata[NUM_CMP-1:0] = status;
				ADDR_IRQ_CLEAR, ADDR_IRQ_SET: next_rdata = '0;
				ADDR_IRQ_ENABLE: next_rdata[NUM_CMP-1:0] = irq_en;
				ADDR_POWER_MODE: next_rdata[1:0] = power_mode;
				ADDR_PORT_DIR: next_rdata[PORT_W-1:0] = port_dir;
				ADDR_PORT_DATA: next_rdata[PORT_W-1:0] = port_data;
				ADDR_PORT_READ: begin
					// Pins owned by a live comparator read back as 0
					if (ctrl[0][BIT_ON] || ctrl[1][BIT_ON]) begin
						next_rdata[PORT_W-1:0] = port_data & ~port_dir;
					end else begin
						next_rdata[PORT_W-1:0] = port_data;
					end
				end
				default: next_rresp = RESP_SLVERR;
			endcase
		end
	end

	// Interrupt, wake and pin drive
	always_comb begin
		next_irq = |(next_status & next_irq_en);
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
		// Wake only on a new event, so a pre-set flag masks it
		next_wake = (power_mode != 2'h0)
			&& |(event_set & ~status);
		for (int i = 0; i < NUM_CMP; i++) begin
			next_pin_oe[i] = ctrl[i][BIT_PIN_SELECT]
				&& !ctrl[i][BIT_PATH_INTERNAL];
			next_pin_val[i] = next_pin_oe[i] && result[i];
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				ctrl[i] <= CTRL_RESET;
			end
			status <= '0;
			irq_en <= '0;
			power_mode <= '0;
			port_dir <= '0;
			port_data <= '0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= '0;
			irq <= 1'b0;
			wake <= 1'b0;
			pin_val <= '0;
			pin_oe <= '0;
			awready <= 1'b1;
			wready <= 1'b1;
			arready <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			status <= next_status;
			irq_en <= next_irq_en;
			power_mode <= next_power_mode;
			port_dir <= next_port_dir;
			port_data <= next_port_data;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			irq <= next_irq;
			wake <= next_wake;
			pin_val <= next_pin_val;
			pin_oe <= next_pin_oe;
			awready <= next_awready;
			wready <= next_wready;
			arready <= next_arready;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_FLAG_ON_CHANGE: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		event_set[0] |=> status[0])
		else $error("channel 0 flag not set on change");
	AST_IRQ_LEVEL: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		(event_set[1] && irq_en[1]) |=> irq)
		else $error("enabled change did not raise interrupt");
	AST_WAKE: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		(power_mode != 2'h0 && |(event_set & ~status)) |=> wake)
		else $error("no wake on change in low power");
	AST_RESERVED_ZERO: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		ctrl[0][2:1] == 2'h0 && ctrl[1][2:1] == 2'h0)
		else $error("reserved bits not zero");
	AST_PIN_PATH: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		(ctrl[0][BIT_PATH_INTERNAL] || !ctrl[0][BIT_PIN_SELECT])
		|=> !cmp_output_pin_oe_out[0])
		else $error("output pin driven while internal");
	AST_RESULT_BIT: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		ctrl[1][BIT_RESULT] == $past(result[1]))
		else $error("result bit lags channel");
	AST_OFF_NO_EVENT: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		!ctrl[0][BIT_ON] |=> ##1 $stable(ctrl[0][BIT_RESULT]))
		else $error("result moved while comparator off");
	AST_SYNC_DELAY: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		($rose(cmp_raw_in[0]) && ctrl[0][BIT_ON] && !ctrl[0][BIT_INVERT])
		##1 (ctrl[0][BIT_ON] && !ctrl[0][BIT_INVERT] && cmp_raw_in[0])
		##1 (ctrl[0][BIT_ON] && !ctrl[0][BIT_INVERT])
		|=> result[0])
		else $error("synchronised result late");
endmodule

/* File: test/analog_source.sv */
`timescale 1ns/100ps
module analog_source
	import cmp_ctrl_pkg::*;
(
	// Wanted comparison per channel
	input wire logic [NUM_CMP-1:0] plus_above_in,
	input wire logic [NUM_CMP-1:0] power_on_in,
	// Raw comparator results
	output logic [NUM_CMP-1:0] raw_out
);
	// ------------------------------------------------------------
	// Settling
	// ------------------------------------------------------------
	// Lags the inputs off the clock grid; unpowered gives no result
	initial raw_out = '0;
	always @(plus_above_in or power_on_in) begin
		raw_out <= #3 plus_above_in & power_on_in;
	end
endmodule

/* File: test/dual_comparator_control_bench.sv */
`timescale 1ns/100ps
module dual_comparator_control_bench;
	import cmp_ctrl_pkg::*;
	logic clk_sys, reset_n, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rd;
	logic [3:0] wstrb;
	logic [1:0] rsp;
	logic [NUM_CMP-1:0] lvl;
	logic inv, path, seen;
	wire logic awready, wready, bvalid, arready, rvalid, irq, wake;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [NUM_CMP-1:0] raw, pwr, hys, sel, pu_off, pin, pin_oe;
	int err_total, checks, seed, i, k;
	// ------------------------------------------------------------
	// Design and analog side
	// ------------------------------------------------------------
	dual_comparator_control #(.PORT_W(2)) dual_comparator_control_i (
		.clk_sys_in(clk_sys), .reset_n_in(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_raw_in(raw),
		.cmp_power_on_out(pwr), .cmp_hysteresis_on_out(hys),
		.cmp_pin_select_out(sel), .cmp_pullup_off_out(pu_off),
		.cmp_output_pin_out(pin), .cmp_output_pin_oe_out(pin_oe),
		.irq_out(irq), .wake_out(wake));
	analog_source analog_source_i (.plus_above_in(lvl), .power_on_in(pwr),
		.raw_out(raw));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, exp, input string w);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, exp, input string w);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %b", $time, w, got);
		end
	endtask
	// ------------------------------------------------------------
	// Bus master; waits are bounded, a hang ends the run
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		logic done;
		done = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1'b1;
				rsp = bresp;
				bready <= 1'b0;
			end
		end
		if (!done) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		logic done;
		done = 1'b0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				done = 1'b1;
				rsp = rresp;
				rd = rdata;
				rready <= 1'b0;
			end
		end
		if (!done) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axi_wr(a, v);
		chk_reg({30'h0, rsp}, {30'h0, RESP_OKAY}, "write resp");
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string w);
		axi_rd(a);
		chk_reg({30'h0, rsp}, {30'h0, RESP_OKAY}, "read resp");
		chk_reg(rd, e, w);
	endtask
	function automatic logic [7:0] ctl(input int c);
		return ADDR_CMP0_CTRL + 8'(c * 4);
	endfunction
	// Control readback: written layout with the live result bit
	function automatic logic [31:0] ctl_exp(input logic [7:0] c,
		input logic r);
		logic [7:0] v;
		v = c;
		v[BIT_RESULT] = r;
		return {24'h0, v};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h3686392d;
		{awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
		{bready, rready, lvl, err_total, checks} = '0;
		wstrb = 4'hf;
		reset_n = 1'b0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		// Reset state and an unmapped place
		rd_chk(ctl(0), {24'h0, CTRL_RESET}, "reset 0");
		rd_chk(ctl(1), {24'h0, CTRL_RESET}, "reset 1");
		rd_chk(ADDR_IRQ_STATUS, 32'h0, "status reset");
		axi_rd(8'h40);
		chk_reg({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped rd");
		axi_wr(8'h40, 32'h0);
		chk_reg({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped wr");
		// Random layout, comparator kept off so the result stays 0
		for (i = 0; i < NUM_CMP; i++) begin
			for (k = 0; k < 3; k++) begin
				d = 8'($random(seed)) & 8'hbf;
				wr(ctl(i), {24'h0, d});
				rd_chk(ctl(i), {24'h0, d & CTRL_WRITE_MASK}, "ctl");
				chk_bit(sel[i], d[7], "pin select");
				chk_bit(pu_off[i], d[7], "pull-high");
				chk_bit(hys[i], d[0], "hysteresis");
				chk_bit(pwr[i], 1'b0, "power");
				chk_bit(pin_oe[i], d[7] & ~d[3], "pin drive");
			end
		end
		// Each channel on, random polarity and path, four edges
		wr(ADDR_IRQ_ENABLE, 32'h3);
		for (i = 0; i < NUM_CMP; i++) begin
			inv = 1'($random(seed));
			path = 1'($random(seed));
			d = {2'b11, inv, 1'b0, path, 3'b001};
			wr(ctl(i), {24'h0, d});
			chk_bit(pwr[i], 1'b1, "power on");
			repeat (8) @(posedge clk_sys);
			wr(ADDR_IRQ_CLEAR, 32'h3);
			for (k = 0; k < 4; k++) begin
				@(posedge clk_sys);
				lvl[i] <= ~lvl[i];
				repeat (8) @(posedge clk_sys);
				rd_chk(ctl(i), ctl_exp(d, lvl[i] ^ inv), "result");
				rd_chk(ADDR_IRQ_STATUS, 32'(1 << i), "flag");
				chk_bit(irq, 1'b1, "irq");
				chk_bit(pin[i], ~path & (lvl[i] ^ inv), "out pin");
				wr(ADDR_IRQ_CLEAR, 32'(1 << i));
				repeat (2) @(posedge clk_sys);
				chk_bit(irq, 1'b0, "irq clear");
			end
		end
		// Sleep: wake on a change, none once the flag is preset
		wr(ADDR_POWER_MODE, 32'h1);
		for (k = 0; k < 2; k++) begin
			wr(ADDR_IRQ_CLEAR, 32'h3);
			if (k == 1) wr(ADDR_IRQ_SET, 32'h2);
			@(posedge clk_sys);
			lvl[1] <= ~lvl[1];
			seen = 1'b0;
			repeat (10) begin
				@(posedge clk_sys);
				seen = seen | wake;
			end
			chk_bit(seen, k == 0, "wake");
			rd_chk(ctl(1), ctl_exp(d, lvl[1] ^ inv), "asleep");
		end
		wr(ADDR_POWER_MODE, 32'h0);
		// A pending flag only reaches the line while enabled
		chk_bit(irq, 1'b1, "irq pending");
		wr(ADDR_IRQ_ENABLE, 32'h0);
		chk_bit(irq, 1'b0, "irq masked");
		// Shared port reads while a comparator is on
		for (k = 0; k < 4; k++) begin
			d = 8'($random(seed));
			wr(ADDR_PORT_DIR, {30'h0, d[1:0]});
			wr(ADDR_PORT_DATA, {30'h0, d[3:2]});
			rd_chk(ADDR_PORT_READ, {30'h0, d[3:2] & ~d[1:0]}, "port");
		end
		// A write without byte 0 strobed leaves the register alone
		wstrb <= 4'he;
		wr(ctl(0), 32'h0);
		wstrb <= 4'hf;
		chk_bit(pwr[0], 1'b1, "unstrobed write");
		// Unused comparators switched off by software
		wr(ctl(0), 32'h81);
		wr(ctl(1), 32'h81);
		rd_chk(ADDR_PORT_READ, {30'h0, d[3:2]}, "port off");
		chk_bit(|pwr, 1'b0, "all off");
		conclude();
	end
endmodule
